// ===== verilog/mdfbc_top.sv
// mdfbc_top: configuration registers for fault response, reporting and
// H-bridge control of a brushed motor driver, reached over I2C.
// assumes comparator and fault inputs synchronous to the 50 MHz clock.
// Summary of operation
// - sense blanking lasts 1.8 us with select bit 0, 1.0 us with 1
// - regulation and stall deglitch lasts 2 us with bit 0, 1 us with 1
// - overcurrent with response bit 0 latches outputs off until clear
// - overcurrent with response bit 1 retries after the retry delay
// - overtemperature latches off at bit 0, resumes on cooling at bit 1
// - internal reference bit 1 fixes reference at 3 V, else external pin
// - two-bit current regulation selector at bits 7..6, reset value 1
// - stall response select at bit 5, read-write, reset value 1
// - stall report enable pulls fault output low while stall detected
// - cycle-by-cycle mode reports regulation on fault output if enabled
// - input scheme bit 0 is phase/enable, 1 is PWM, reset 1
// - bridge control from pins at source bit 0, register bits at 1
// - software bridge bits used only while source bit is 1
// - writing 1 to fault clear clears latched faults, bit self-clears
// - regulation scheme 01 selects cycle-by-cycle current regulation
// - register-driven bridge PWM runs at 50 kHz or 25 kHz by rate bit
`timescale 1ns/100ps
module mdfbc_top
	import mdfbc_pkg::*;
#(
	parameter int         RETRY_CYCLES = RETRY_CYC_DEF,
	parameter logic [6:0] TARGET_ADDR  = TARGET_ADDR_DEF
) (
	input  wire logic       ref_clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output wire logic       sda_out,
	output wire logic       sda_oe_n_out,
	input  wire logic [1:0] bridge_input_pins_in,
	input  wire logic       overcurrent_event_in,
	input  wire logic       thermal_shutdown_event_in,
	input  wire logic       current_trip_in,
	input  wire logic       stall_raw_in,
	output wire logic       fault_indicator_low_out,
	output wire logic       bridge_enable_out,
	output wire logic       half_bridge_a_out,
	output wire logic       half_bridge_b_out,
	output wire logic       current_regulating_out,
	output wire logic       sense_blank_active_out,
	output wire logic       stall_detected_out,
	output wire logic       vref_internal_3v_out,
	output wire logic [1:0] current_reg_behavior_sel_out
);

	generate
		if (RETRY_CYCLES < 1 || RETRY_CYCLES > 65535) begin : g_bad_retry
			$error("RETRY_CYCLES must lie in 1..65535");
		end
	endgenerate

	localparam logic [6:0]  BLANK_L = 7'(BLANK_LONG_CYC);
	localparam logic [6:0]  BLANK_S = 7'(BLANK_SHORT_CYC);
	localparam logic [6:0]  DEG_L   = 7'(DEG_LONG_CYC);
	localparam logic [6:0]  DEG_S   = 7'(DEG_SHORT_CYC);
	localparam logic [10:0] HALF_F  = 11'(PWM_FAST_HALF - 1);
	localparam logic [10:0] HALF_S  = 11'(PWM_SLOW_HALF - 1);
	localparam logic [15:0] RETRY_L = 16'(RETRY_CYCLES);

	// returns {enable, a_high, b_high}
	function automatic logic [2:0] drive_decode(input logic pwm_mode,
	                                            input logic [1:0] ins);
		logic [2:0] res;
		res = 3'h0;
		if (pwm_mode) begin
			case (ins)
				2'h0:    res = 3'h0;
				2'h1:    res = 3'h5;
				2'h2:    res = 3'h6;
				default: res = 3'h4;
			endcase
		end else begin
			// one = enable, two = phase; enable low brakes on low sides
			res = !ins[1] ? 3'h4 : (ins[0] ? 3'h6 : 3'h5);
		end
		return res;
	endfunction : drive_decode

	// register bus
	logic [7:0] reg_addr;
	logic [7:0] wr_data;
	logic       wr_en;
	logic [7:0] rd_data;

	logic [7:0] response_ff;
	logic [7:0] report_ff;
	logic [7:0] scheme_ff;
	logic       clear_pulse_ff;

	// protection and detection state
	logic [6:0]  blank_cnt_ff;
	logic [6:0]  trip_cnt_ff;
	logic [6:0]  stall_cnt_ff;
	logic [15:0] retry_cnt_ff;
	logic        ocp_latch_ff;
	logic        tsd_latch_ff;
	logic        stall_latch_ff;
	logic        fault_n_ff;

	// bridge
	logic [10:0] pwm_cnt_ff;
	logic        carrier_ff;
	logic [2:0]  drive_ff;

	mdfbc_i2c_target #(
		.TARGET_ADDR (TARGET_ADDR)
	) u_i2c (
		.ref_clk_in   (ref_clk_in),
		.rst_n_in     (rst_n_in),
		.scl_in       (scl_in),
		.sda_in       (sda_in),
		.sda_out      (sda_out),
		.sda_oe_n_out (sda_oe_n_out),
		.rd_data_in   (rd_data),
		.reg_addr_out (reg_addr),
		.wr_data_out  (wr_data),
		.wr_en_out    (wr_en)
	);

	wire wr_fault_ctrl = wr_en && (reg_addr == FAULT_CTRL_OFS);
	wire wr_response   = wr_en && (reg_addr == RESPONSE_OFS);
	wire wr_report     = wr_en && (reg_addr == REPORT_OFS);
	wire wr_scheme     = wr_en && (reg_addr == SCHEME_OFS);

	// clear bit never reads back as 1 since the fault control offset falls to the 8'h00 default
	assign rd_data = (reg_addr == RESPONSE_OFS) ? response_ff :
	                 (reg_addr == REPORT_OFS)   ? report_ff   :
	                 (reg_addr == SCHEME_OFS)   ? scheme_ff   : 8'h00;

	// field decode
	wire [1:0] cur_reg_sel = response_ff[CUR_REG_LSB +: 2];
	wire stall_resp_sel    = response_ff[STALL_RESP_BIT];
	wire blank_sel         = response_ff[BLANK_SEL_BIT];
	wire deg_sel           = response_ff[DEG_SEL_BIT];
	wire ocp_resp_sel      = response_ff[OCP_RESP_BIT];
	wire tsd_resp_sel      = response_ff[TSD_RESP_BIT];
	wire stall_report_en   = report_ff[STALL_REPORT_BIT];
	wire cbc_report_en     = report_ff[CBC_REPORT_BIT];
	wire pwm_mode          = report_ff[INPUT_MODE_BIT];
	wire soft_src          = report_ff[SRC_SEL_BIT];
	wire [1:0] scheme_sel  = scheme_ff[SCHEME_LSB +: 2];
	wire pwm_slow          = scheme_ff[PWM_RATE_BIT];

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			response_ff <= RESPONSE_RST;
		end else if (wr_response) begin
			response_ff <= wr_data;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			report_ff <= REPORT_RST;
		end else if (wr_report) begin
			report_ff <= wr_data & REPORT_RW_MASK;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			scheme_ff <= SCHEME_RST;
		end else if (wr_scheme) begin
			scheme_ff <= wr_data & SCHEME_RW_MASK;
		end
	end

	// clear lives one cycle only, so the bit self-clears
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			clear_pulse_ff <= 1'b0;
		end else begin
			clear_pulse_ff <= wr_fault_ctrl & wr_data[CLEAR_BIT];
		end
	end

	// timing selections
	wire [6:0]  blank_len = blank_sel ? BLANK_S : BLANK_L;
	wire [6:0]  deg_len   = deg_sel ? DEG_S : DEG_L;
	wire [10:0] pwm_half  = pwm_slow ? HALF_S : HALF_F;

	// deglitched detections
	wire blanking     = (blank_cnt_ff != 7'h00);
	wire regulating   = (trip_cnt_ff >= deg_len);
	wire stall_det    = (stall_cnt_ff >= deg_len);
	wire trip_qual    = current_trip_in & ~blanking;
	wire retry_active = (retry_cnt_ff != 16'h0000);
	wire cbc_mode     = (scheme_sel == SCHEME_CBC);

	// latched faults: a new event in the clear cycle wins over the clear
	wire ocp_set   = overcurrent_event_in & ~ocp_resp_sel;
	wire tsd_set   = thermal_shutdown_event_in & ~tsd_resp_sel;
	wire stall_set = stall_det & ~stall_resp_sel;
	wire nxt_ocp_latch   = ocp_set | (ocp_latch_ff & ~clear_pulse_ff);
	wire nxt_tsd_latch   = tsd_set | (tsd_latch_ff & ~clear_pulse_ff);
	wire nxt_stall_latch = stall_set | (stall_latch_ff & ~clear_pulse_ff);

	// auto-retry holds outputs off while the delay runs
	wire retry_load = overcurrent_event_in & ocp_resp_sel;
	wire tsd_auto   = thermal_shutdown_event_in & tsd_resp_sel;
	wire outputs_off = ocp_latch_ff | tsd_latch_ff | stall_latch_ff |
	                   retry_active | tsd_auto;

	// bridge source and PWM generation
	wire carrier_wrap = (pwm_cnt_ff >= pwm_half);
	wire [1:0] soft_bits = {report_ff[SOFT_ONE_BIT], report_ff[SOFT_TWO_BIT]};
	wire [1:0] soft_mod  = pwm_mode ? (carrier_ff ? soft_bits : 2'h0) :
	                       {soft_bits[1] & carrier_ff, soft_bits[0]};
	wire [1:0] bridge_ins = soft_src ? soft_mod :
	                        bridge_input_pins_in;
	wire [2:0] nxt_drive = outputs_off ? 3'h0 :
	                       drive_decode(pwm_mode, bridge_ins);
	wire drive_change = (nxt_drive != drive_ff) & nxt_drive[2];

	wire nxt_fault_n = ~(ocp_latch_ff | tsd_latch_ff | stall_latch_ff |
	                     retry_active | thermal_shutdown_event_in |
	                     (stall_report_en & stall_det) |
	                     (cbc_mode & cbc_report_en & regulating));

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			blank_cnt_ff <= 7'h00;
		end else if (drive_change) begin
			blank_cnt_ff <= blank_len;
		end else if (blanking) begin
			blank_cnt_ff <= blank_cnt_ff - 7'h01;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			trip_cnt_ff <= 7'h00;
		end else if (!trip_qual) begin
			trip_cnt_ff <= 7'h00;
		end else if (!regulating) begin
			trip_cnt_ff <= trip_cnt_ff + 7'h01;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stall_cnt_ff <= 7'h00;
		end else if (!stall_raw_in) begin
			stall_cnt_ff <= 7'h00;
		end else if (!stall_det) begin
			stall_cnt_ff <= stall_cnt_ff + 7'h01;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ocp_latch_ff   <= 1'b0;
			tsd_latch_ff   <= 1'b0;
			stall_latch_ff <= 1'b0;
		end else begin
			ocp_latch_ff   <= nxt_ocp_latch;
			tsd_latch_ff   <= nxt_tsd_latch;
			stall_latch_ff <= nxt_stall_latch;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			retry_cnt_ff <= 16'h0000;
		end else if (retry_load) begin
			retry_cnt_ff <= RETRY_L;
		end else if (retry_active) begin
			retry_cnt_ff <= retry_cnt_ff - 16'h0001;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fault_n_ff <= 1'b1;
		end else begin
			fault_n_ff <= nxt_fault_n;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pwm_cnt_ff <= 11'h000;
			carrier_ff <= 1'b0;
			drive_ff   <= 3'h0;
		end else begin
			pwm_cnt_ff <= carrier_wrap ? 11'h000 : pwm_cnt_ff + 11'h001;
			if (carrier_wrap)
				carrier_ff <= ~carrier_ff;
			drive_ff <= nxt_drive;
		end
	end

	assign fault_indicator_low_out      = fault_n_ff;
	assign bridge_enable_out            = drive_ff[2];
	assign half_bridge_a_out            = drive_ff[1];
	assign half_bridge_b_out            = drive_ff[0];
	assign current_regulating_out       = regulating;
	assign sense_blank_active_out       = blanking;
	assign stall_detected_out           = stall_det;
	assign vref_internal_3v_out         = response_ff[INT_VREF_BIT];
	assign current_reg_behavior_sel_out = cur_reg_sel;

endmodule : mdfbc_top

// ===== verilog/mdfbc_pkg.sv
// mdfbc_pkg: register map, field positions, reset values and timing counts
// for the motor driver configuration block.
// assumes a single 50 MHz device clock.
package mdfbc_pkg;

	localparam int CLK_FREQ_MHZ = 50;
	localparam int CLK_FREQ_HZ  = 50_000_000;

	// register offsets and reset values
	localparam logic [7:0] FAULT_CTRL_OFS   = 8'h09;
	localparam logic [7:0] RESPONSE_OFS     = 8'h0c;
	localparam logic [7:0] RESPONSE_RST     = 8'h63;
	localparam logic [7:0] REPORT_OFS       = 8'h0d;
	localparam logic [7:0] REPORT_RST       = 8'h38;
	localparam logic [7:0] REPORT_RW_MASK   = 8'h3f;
	localparam logic [7:0] SCHEME_OFS       = 8'h0e;
	localparam logic [7:0] SCHEME_RST       = 8'h04;
	localparam logic [7:0] SCHEME_RW_MASK   = 8'h1c;

	// fault control fields
	localparam int CLEAR_BIT       = 1;
	// regulation and fault response fields
	localparam int CUR_REG_LSB     = 6;
	localparam int STALL_RESP_BIT  = 5;
	localparam int INT_VREF_BIT    = 4;
	localparam int BLANK_SEL_BIT   = 3;
	localparam int DEG_SEL_BIT     = 2;
	localparam int OCP_RESP_BIT    = 1;
	localparam int TSD_RESP_BIT    = 0;
	// report and bridge control fields
	localparam int STALL_REPORT_BIT = 5;
	localparam int CBC_REPORT_BIT  = 4;
	localparam int INPUT_MODE_BIT  = 3;
	localparam int SRC_SEL_BIT     = 2;
	localparam int SOFT_ONE_BIT    = 1;
	localparam int SOFT_TWO_BIT    = 0;
	// regulation scheme fields
	localparam int SCHEME_LSB      = 3;
	localparam int PWM_RATE_BIT    = 2;
	localparam logic [1:0] SCHEME_CBC = 2'h1;

	// timing
	localparam int BLANK_LONG_NS   = 1800;
	localparam int BLANK_SHORT_NS  = 1000;
	localparam int DEG_LONG_NS     = 2000;
	localparam int DEG_SHORT_NS    = 1000;
	localparam int BLANK_LONG_CYC  = (BLANK_LONG_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int BLANK_SHORT_CYC = (BLANK_SHORT_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int DEG_LONG_CYC    = (DEG_LONG_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int DEG_SHORT_CYC   = (DEG_SHORT_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int PWM_FAST_HZ     = 50000;
	localparam int PWM_SLOW_HZ     = 25000;
	localparam int PWM_FAST_HALF   = CLK_FREQ_HZ / (2 * PWM_FAST_HZ);
	localparam int PWM_SLOW_HALF   = CLK_FREQ_HZ / (2 * PWM_SLOW_HZ);
	localparam int RETRY_TIME_US   = 1000;
	localparam int RETRY_CYC_DEF   = RETRY_TIME_US * CLK_FREQ_MHZ;

	// bus target address, value is arbitrary
	localparam logic [6:0] TARGET_ADDR_DEF = 7'h30;

	typedef enum logic [3:0] {
		I2C_IDLE     = 4'h0,
		I2C_ADDR     = 4'h1,
		I2C_ADDR_ACK = 4'h3,
		I2C_PTR      = 4'h2,
		I2C_PTR_ACK  = 4'h6,
		I2C_WDATA    = 4'h7,
		I2C_WDAT_ACK = 4'h5,
		I2C_RDATA    = 4'h4,
		I2C_RDAT_ACK = 4'hc
	} mdfbc_i2c_state_t;

endpackage : mdfbc_pkg

// ===== verilog/mdfbc_i2c_target.sv
// mdfbc_i2c_target: I2C target with register pointer and auto-increment.
// assumes scl and sda levels are already synchronous to the clock and
// that the clock is far faster than scl.
`timescale 1ns/100ps
module mdfbc_i2c_target
	import mdfbc_pkg::*;
#(
	parameter logic [6:0] TARGET_ADDR = TARGET_ADDR_DEF
) (
	input  wire logic       ref_clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output wire logic       sda_out,
	output wire logic       sda_oe_n_out,
	input  wire logic [7:0] rd_data_in,
	output wire logic [7:0] reg_addr_out,
	output wire logic [7:0] wr_data_out,
	output wire logic       wr_en_out
);

	mdfbc_i2c_state_t state_ff;
	logic       scl_q_ff;
	logic       sda_q_ff;
	logic [3:0] bit_cnt_ff;
	logic [7:0] shift_ff;
	logic [7:0] ptr_ff;
	logic [7:0] wr_data_ff;
	logic       wr_en_ff;
	logic       drive_low_ff;
	logic       nack_ff;

	wire scl_rise   = scl_in & ~scl_q_ff;
	wire scl_fall   = ~scl_in & scl_q_ff;
	wire start_cond = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
	wire stop_cond  = scl_in & scl_q_ff & ~sda_q_ff & sda_in;
	wire byte_full  = (bit_cnt_ff == 4'h8);
	wire [7:0] ptr_inc = ptr_ff + 8'h01;

	assign sda_out      = 1'b0;
	assign sda_oe_n_out = ~drive_low_ff;
	assign reg_addr_out = ptr_ff;
	assign wr_data_out  = wr_data_ff;
	assign wr_en_out    = wr_en_ff;

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_ff     <= I2C_IDLE;
			scl_q_ff     <= 1'b1;
			sda_q_ff     <= 1'b1;
			bit_cnt_ff   <= 4'h0;
			shift_ff     <= 8'h00;
			ptr_ff       <= 8'h00;
			wr_data_ff   <= 8'h00;
			wr_en_ff     <= 1'b0;
			drive_low_ff <= 1'b0;
			nack_ff      <= 1'b0;
		end else begin
			scl_q_ff <= scl_in;
			sda_q_ff <= sda_in;
			wr_en_ff <= 1'b0;
			if (start_cond) begin
				state_ff     <= I2C_ADDR;
				bit_cnt_ff   <= 4'h0;
				drive_low_ff <= 1'b0;
			end else if (stop_cond) begin
				state_ff     <= I2C_IDLE;
				drive_low_ff <= 1'b0;
			end else if (scl_rise) begin
				case (state_ff)
					I2C_ADDR, I2C_PTR, I2C_WDATA: begin
						shift_ff   <= {shift_ff[6:0], sda_in};
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
					end
					I2C_RDATA: bit_cnt_ff <= bit_cnt_ff + 4'h1;
					I2C_RDAT_ACK: nack_ff <= sda_in;
					default: ;
				endcase
			end else if (scl_fall) begin
				case (state_ff)
					I2C_ADDR: begin
						if (byte_full && shift_ff[7:1] == TARGET_ADDR) begin
							state_ff     <= I2C_ADDR_ACK;
							drive_low_ff <= 1'b1;
						end else if (byte_full) begin
							state_ff <= I2C_IDLE;
						end
					end
					I2C_ADDR_ACK: begin
						bit_cnt_ff <= 4'h0;
						if (shift_ff[0]) begin
							state_ff     <= I2C_RDATA;
							shift_ff     <= rd_data_in;
							drive_low_ff <= ~rd_data_in[7];
						end else begin
							state_ff     <= I2C_PTR;
							drive_low_ff <= 1'b0;
						end
					end
					I2C_PTR: begin
						if (byte_full) begin
							state_ff     <= I2C_PTR_ACK;
							ptr_ff       <= shift_ff;
							drive_low_ff <= 1'b1;
						end
					end
					I2C_PTR_ACK, I2C_WDAT_ACK: begin
						state_ff     <= I2C_WDATA;
						bit_cnt_ff   <= 4'h0;
						drive_low_ff <= 1'b0;
					end
					I2C_WDATA: begin
						if (byte_full) begin
							state_ff     <= I2C_WDAT_ACK;
							wr_data_ff   <= shift_ff;
							wr_en_ff     <= 1'b1;
							drive_low_ff <= 1'b1;
						end
					end
					I2C_RDATA: begin
						if (byte_full) begin
							state_ff     <= I2C_RDAT_ACK;
							drive_low_ff <= 1'b0;
							ptr_ff       <= ptr_inc;
						end else begin
							shift_ff     <= {shift_ff[6:0], 1'b0};
							drive_low_ff <= ~shift_ff[6];
						end
					end
					I2C_RDAT_ACK: begin
						bit_cnt_ff <= 4'h0;
						if (nack_ff) begin
							state_ff <= I2C_IDLE;
						end else begin
							state_ff     <= I2C_RDATA;
							shift_ff     <= rd_data_in;
							drive_low_ff <= ~rd_data_in[7];
						end
					end
					default: state_ff <= I2C_IDLE;
				endcase
			end else if (wr_en_ff) begin
				// pointer advances on the same edge as the register write that uses it
				ptr_ff <= ptr_inc;
			end
		end
	end

endmodule : mdfbc_i2c_target

// ===== testbench/mdfbc_cfg_monitor.sv
// mdfbc_cfg_monitor: port-level checks on fault, deglitch, blanking and
// configuration outputs. assumes binding to mdfbc_top, one clock domain.
`timescale 1ns/100ps
module mdfbc_cfg_monitor (
	input wire logic       ref_clk_in,
	input wire logic       rst_n_in,
	input wire logic       scl_in,
	input wire logic       overcurrent_event_in,
	input wire logic       thermal_shutdown_event_in,
	input wire logic       current_trip_in,
	input wire logic       stall_raw_in,
	input wire logic       fault_indicator_low_out,
	input wire logic       bridge_enable_out,
	input wire logic       current_regulating_out,
	input wire logic       sense_blank_active_out,
	input wire logic       stall_detected_out,
	input wire logic       vref_internal_3v_out,
	input wire logic [1:0] current_reg_behavior_sel_out
);
	default clocking mon_cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	ocp_fault_low_a: assert property (
		overcurrent_event_in |-> ##2 !fault_indicator_low_out)
		else $error("fault output high after overcurrent");
	ocp_bridge_off_a: assert property (
		overcurrent_event_in |-> ##2 !bridge_enable_out)
		else $error("bridge still driven after overcurrent");
	tsd_fault_low_a: assert property (
		thermal_shutdown_event_in |=> !fault_indicator_low_out)
		else $error("fault output high after overtemperature");
	stall_deglitch_a: assert property (
		stall_detected_out |-> $past(stall_raw_in) && $past(stall_raw_in, 40))
		else $error("stall detected without a held stall input");
	trip_deglitch_a: assert property (
		current_regulating_out |->
		$past(current_trip_in) && $past(current_trip_in, 40))
		else $error("regulation seen without a held trip input");
	blank_hold_a: assert property (
		$rose(sense_blank_active_out) |-> sense_blank_active_out[*8])
		else $error("blanking interval ended too early");
	reset_values_a: assert property (
		$rose(rst_n_in) |->
		current_reg_behavior_sel_out == 2'h1 && !vref_internal_3v_out)
		else $error("configuration outputs wrong after reset");
	cfg_scl_low_a: assert property (
		$changed(current_reg_behavior_sel_out) ||
		$changed(vref_internal_3v_out) |-> !scl_in)
		else $error("configuration changed outside a bus write");

	cover property (stall_detected_out && !fault_indicator_low_out);
	cover property (current_regulating_out);
	cover property ($fell(bridge_enable_out));
endmodule : mdfbc_cfg_monitor

bind mdfbc_top mdfbc_cfg_monitor u_cfg_mon (.*);

// ===== testbench/mdfbc_host_model.sv
// mdfbc_host_model: bus controller that writes and reads registers.
// assumes an external pull-up resolves the data line when released.
`timescale 1ns/100ps
module mdfbc_host_model #(
	parameter int HALF = 8
) (
	input  wire logic ref_clk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_low_out
);
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_in);
		#2;
	endtask : tick
	task automatic start_cond();
		sda_low_out = 1'b0;
		tick(HALF);
		scl_out = 1'b1;
		tick(HALF);
		sda_low_out = 1'b1;
		tick(HALF);
		scl_out = 1'b0;
		tick(HALF);
	endtask : start_cond
	task automatic stop_cond();
		sda_low_out = 1'b1;
		tick(HALF);
		scl_out = 1'b1;
		tick(HALF);
		sda_low_out = 1'b0;
		tick(HALF);
	endtask : stop_cond
	task automatic clk_bit(input logic b, output logic got);
		sda_low_out = !b;
		tick(HALF);
		scl_out = 1'b1;
		tick(HALF);
		got = sda_in;
		scl_out = 1'b0;
		tick(HALF);
	endtask : clk_bit
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--)
			clk_bit(b[i], g);
		clk_bit(1'b1, g);
		ack = !g;
	endtask : put_byte
	task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
			input logic [7:0] d, output logic ok);
		logic a0, a1, a2;
		start_cond();
		put_byte({dev, 1'b0}, a0);
		put_byte(ofs, a1);
		put_byte(d, a2);
		stop_cond();
		ok = a0 & a1 & a2;
	endtask : write_reg
	task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs,
			output logic [7:0] d, output logic ok);
		logic a0, a1, a2, g;
		start_cond();
		put_byte({dev, 1'b0}, a0);
		put_byte(ofs, a1);
		start_cond();
		put_byte({dev, 1'b1}, a2);
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, g);
			d[i] = g;
		end
		clk_bit(1'b1, g);
		stop_cond();
		ok = a0 & a1 & a2;
	endtask : read_reg
endmodule : mdfbc_host_model

// ===== testbench/test_motor_driver_fault_bridge_config.sv
// test_motor_driver_fault_bridge_config: register, bridge and fault tests.
// assumes the host model on the bus and a pull-up on the data line.
`timescale 1ns/100ps
module test_motor_driver_fault_bridge_config
	import mdfbc_pkg::*;
();
	localparam int RETRY = 20;
	localparam int IE = 0, IB = 1, IS = 2, IR = 3;
	logic ref_clk_in, rst_n_in, scl, host_low, sda_line, sda_o, oe_n;
	logic overcurrent_event, thermal_shutdown_event, trip, stall, fault_o, en_o, a_o, b_o;
	logic reg_o, blank_o, stall_o, vref_o;
	logic [1:0] pins, sel_o;
	logic [3:0] obs;
	int bad_count, compares;
	assign sda_line = host_low ? 1'b0 : (oe_n ? 1'b1 : sda_o);
	assign obs = {reg_o, stall_o, blank_o, en_o};
	mdfbc_host_model host (.ref_clk_in(ref_clk_in), .sda_in(sda_line),
		.scl_out(scl), .sda_low_out(host_low));
	mdfbc_top #(.RETRY_CYCLES(RETRY)) DUT (.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_o), .sda_oe_n_out(oe_n), .bridge_input_pins_in(pins),
		.overcurrent_event_in(overcurrent_event), .thermal_shutdown_event_in(thermal_shutdown_event),
		.current_trip_in(trip), .stall_raw_in(stall),
		.fault_indicator_low_out(fault_o), .bridge_enable_out(en_o),
		.half_bridge_a_out(a_o), .half_bridge_b_out(b_o),
		.current_regulating_out(reg_o), .sense_blank_active_out(blank_o),
		.stall_detected_out(stall_o), .vref_internal_3v_out(vref_o),
		.current_reg_behavior_sel_out(sel_o));
	always #10 ref_clk_in = ~ref_clk_in;
	task automatic complete_run();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_n(input int got, input int lo, input int hi);
		compares++;
		if (got < lo || got > hi) begin
			bad_count++;
			$display("BAD %0t count %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask : chk_n
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
		#2;
	endtask : cyc
	task automatic span(input int idx, input logic lvl, output int n);
		n = 0;
		while (obs[idx] === lvl) begin
			cyc(1);
			n++;
			if (n > 3000) begin
				bad_count++;
				$display("BAD %0t wait limit reached", $time);
				complete_run();
			end
		end
	endtask : span
	task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
		logic ok;
		host.write_reg(TARGET_ADDR_DEF, ofs, d, ok);
		chk(ok, 8'h01);
	endtask : wr
	task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
		logic [7:0] d;
		logic       ok;
		host.read_reg(TARGET_ADDR_DEF, ofs, d, ok);
		chk(ok, 8'h01);
		chk(d, exp);
	endtask : rd
	initial begin
		logic [7:0] d;
		int         n;
		int         h;
		ref_clk_in = 1'b0;
		{rst_n_in, overcurrent_event, thermal_shutdown_event, trip, stall, pins} = 7'h00;
		cyc(6);
		rst_n_in = 1'b1;
		chk(sel_o, 8'h01);
		chk(vref_o, 8'h00);
		rd(RESPONSE_OFS, RESPONSE_RST);
		rd(REPORT_OFS, REPORT_RST);
		wr(REPORT_OFS, 8'hc8);
		rd(REPORT_OFS, 8'h08);
		rd(8'h20, 8'h00);
		for (int i = 0; i < 4; i++) begin
			d = {i[1:0], i[0] ? 6'h1c : 6'h23};
			wr(RESPONSE_OFS, d);
			rd(RESPONSE_OFS, d);
			chk(sel_o, i[1:0]);
			chk(vref_o, d[4]);
		end
		for (int i = 0; i < 2; i++) begin
			wr(RESPONSE_OFS, i ? 8'h63 : 8'h6b);
			pins = i ? 2'h2 : 2'h1;
			span(IB, 1'b0, n);
			span(IB, 1'b1, n);
			chk_n(n, i ? 89 : 49, i ? 91 : 51);
		end
		chk({en_o, a_o, b_o}, 8'h06);
		wr(REPORT_OFS, 8'h28);
		for (int i = 0; i < 2; i++) begin
			wr(RESPONSE_OFS, i ? 8'h67 : 8'h63);
			stall = 1'b1;
			span(IS, 1'b0, n);
			chk_n(n, i ? 48 : 98, i ? 52 : 102);
			cyc(3);
			chk(fault_o, 8'h00);
			stall = 1'b0;
			cyc(3);
		end
		wr(REPORT_OFS, 8'h08);
		stall = 1'b1;
		cyc(80);
		chk({stall_o, fault_o}, 8'h03);
		stall = 1'b0;
		for (int i = 0; i < 3; i++) begin
			wr(SCHEME_OFS, i == 2 ? 8'h04 : 8'h0c);
			wr(REPORT_OFS, i == 1 ? 8'h08 : 8'h18);
			trip = 1'b1;
			span(IR, 1'b0, n);
			cyc(3);
			chk(fault_o, i != 0);
			trip = 1'b0;
		end
		wr(RESPONSE_OFS, 8'h65);
		overcurrent_event = 1'b1;
		cyc(1);
		overcurrent_event = 1'b0;
		cyc(40);
		chk({fault_o, en_o}, 8'h00);
		wr(FAULT_CTRL_OFS, 8'h02);
		cyc(3);
		chk({fault_o, en_o}, 8'h03);
		rd(FAULT_CTRL_OFS, 8'h00);
		wr(RESPONSE_OFS, 8'h67);
		overcurrent_event = 1'b1;
		cyc(1);
		overcurrent_event = 1'b0;
		cyc(3);
		span(IE, 1'b0, n);
		chk_n(n, RETRY - 8, RETRY);
		for (int i = 0; i < 2; i++) begin
			wr(RESPONSE_OFS, i ? 8'h66 : 8'h67);
			thermal_shutdown_event = 1'b1;
			cyc(5);
			chk(fault_o, 8'h00);
			thermal_shutdown_event = 1'b0;
			cyc(5);
			chk(fault_o, !i[0]);
		end
		wr(FAULT_CTRL_OFS, 8'h02);
		cyc(3);
		chk(fault_o, 8'h01);
		wr(REPORT_OFS, 8'h0a);
		pins = 2'h0;
		cyc(3);
		chk(en_o, 8'h00);
		wr(REPORT_OFS, 8'h0e);
		for (int i = 0; i < 2; i++) begin
			wr(SCHEME_OFS, i ? 8'h00 : 8'h04);
			span(IE, 1'b1, n);
			span(IE, 1'b0, n);
			chk({en_o, a_o, b_o}, 8'h06);
			span(IE, 1'b1, n);
			h = i ? PWM_FAST_HALF : PWM_SLOW_HALF;
			chk_n(n, h - 1, h + 1);
		end
		wr(REPORT_OFS, 8'h00);
		for (int i = 1; i < 4; i++) begin
			pins = i[1:0];
			cyc(3);
			chk({en_o, a_o, b_o}, i == 1 ? 8'h04 : 8'h03 + i);
		end
		complete_run();
	end
endmodule : test_motor_driver_fault_bridge_config
